/* File: design/fmsp_serial_port.v */
// Notes on behaviour
// [RULE_01] full duplex; receive runs while buffer unread
// [RULE_02] one address: write transmits, read gets receive
// [RULE_03] two-bit mode picks shift, 8-bit, 9-bit modes
// [RULE_04] 8-bit mode filter: bad stop, no flag
// [RULE_05] 9-bit mode filter: ninth zero, no flag
// [RULE_06] receive enable gates every reception start
// [RULE_07] transmit ninth bit sent in 9-bit modes
// [RULE_08] receive ninth status: ninth bit or stop
// [RULE_09] transmit done set; software clears
// [RULE_10] receive done set; software clears
// [RULE_11] shift mode: eight bits lsb first, clock out
// [RULE_12] shift mode receive starts when flag clear
// [RULE_13] 8-bit frame: start, eight data, stop
// [RULE_14] 8-bit load puts stop one in ninth
// [RULE_15] async receive starts on falling edge
// [RULE_16] final shift stores byte only if allowed
// [RULE_17] fixed 9-bit frame carries eleven bits
// [RULE_18] fixed rate: core clock over 64 or 32
// [RULE_19] fixed mode transmit waits next baud tick
// [RULE_20] variable 9-bit uses external baud pulses
// [RULE_21] shift clock is core clock over 12
// [RULE_22] per-direction select between two timers
// [RULE_23] sixteen baud pulses per bit time
// [RULE_24] surroundings supply one-cycle overflow pulses
// [RULE_25] receive pin synchronised before edge detect
`timescale 1ns/1ps
`include "fmsp_consts.vh"

// ****************************************
// transmit buffer fifo
// ****************************************
module fmsp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             core_clk_in,
  input  wire             rst_in,
  // filling side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // draining side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // fmsp_fifo

// ****************************************
// serial port top
// ****************************************
module fmsp_serial_port #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // clock and reset
  input  wire       core_clk_in,
  input  wire       rst_in,
  // special-function register port
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_wr_in,
  input  wire       sfr_rd_in,
  input  wire [7:0] sfr_wdata_in,
  output reg  [7:0] sfr_rdata_out,
  // baud sources from surrounding timers
  input  wire       baud_double_in,
  input  wire       rx_clock_select_in,
  input  wire       tx_clock_select_in,
  input  wire       t1_ovf_tx_in,
  input  wire       t2_ovf_tx_in,
  input  wire       t1_ovf_rx_in,
  input  wire       t2_ovf_rx_in,
  // serial pins
  input  wire       rxd_in,
  output reg        rxd_out,
  output reg        rxd_oe_out,
  output reg        txd_out,
  // transmit buffer has room
  output reg        tx_space_out
);
  localparam IDLE = 1'b0;
  localparam RUN  = 1'b1;

  reg  [7:0] ctl;
  reg  [7:0] rbuf;
  wire [1:0] mode;
  wire       mode_shift;
  wire       mode_nine;

  assign mode = {ctl[`FMSP_MODE_HI], ctl[`FMSP_MODE_LO]}; // RULE_03
  assign mode_shift = (mode == `FMSP_MODE_SHIFT);
  assign mode_nine  = ctl[`FMSP_MODE_HI];

  // ****************************************
  // buffer write path
  // ****************************************
  wire       buf_wr;
  wire       fifo_in_ready;
  wire       fifo_valid;
  wire [7:0] fifo_data;
  reg        fifo_pop;

  // writes into a full buffer are dropped; software polls tx_space_out
  assign buf_wr = sfr_wr_in & (sfr_addr_in == `FMSP_ADDR_BUF); // RULE_02

  fmsp_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_tx_fifo (
    .core_clk_in   (core_clk_in),
    .rst_in        (rst_in),
    .in_valid_in   (buf_wr),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (sfr_wdata_in),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_data)
  );

  // ****************************************
  // rate dividers
  // ****************************************
  reg  [3:0] shift_div;
  reg  [1:0] fix_div;
  reg  [3:0] tx_ph;
  wire       shift_lo;
  wire       shift_hi;
  wire       fix_last;
  wire       fix_os;
  wire       tx_os;
  wire       rx_os;
  wire       tx_bit;

  assign shift_lo = (shift_div == 4'h0);
  assign shift_hi = (shift_div == `FMSP_SHIFT_HALF);
  assign fix_last = baud_double_in ? (fix_div == `FMSP_FIX_FAST_LAST)
                                   : (fix_div == `FMSP_FIX_SLOW_LAST); // RULE_18
  assign fix_os = fix_last;
  assign tx_os = (mode == `FMSP_MODE_A9_FIX) ? fix_os :
                 tx_clock_select_in ? t2_ovf_tx_in : t1_ovf_tx_in; // RULE_22
  assign rx_os = (mode == `FMSP_MODE_A9_FIX) ? fix_os :
                 rx_clock_select_in ? t2_ovf_rx_in : t1_ovf_rx_in; // RULE_20
  assign tx_bit = tx_os & (tx_ph == `FMSP_OVS_LAST); // RULE_23

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      shift_div <= 4'h0;
      fix_div   <= 2'h0;
      tx_ph     <= 4'h0;
    end else begin
      if (shift_div == `FMSP_SHIFT_LAST) begin // RULE_21
        shift_div <= 4'h0;
      end else begin
        shift_div <= shift_div + 4'h1;
      end
      if (fix_last) begin
        fix_div <= 2'h0;
      end else begin
        fix_div <= fix_div + 2'h1;
      end
      // free-running so a frame starts only on a bit boundary
      if (tx_os) begin
        tx_ph <= tx_ph + 4'h1;
      end
    end
  end

  // ****************************************
  // shift mode and async transmit
  // ****************************************
  reg       tx_st;
  reg       sh_dir;
  reg [3:0] sh_cnt;
  reg [7:0] sh_reg;
  reg [9:0] tx_sh;
  reg [3:0] tx_cnt;
  reg       tx_done_set;
  reg       sh_rx_take;

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      tx_st       <= IDLE;
      sh_dir      <= 1'b0;
      sh_cnt      <= 4'h0;
      sh_reg      <= 8'h00;
      tx_sh       <= 10'h3ff;
      tx_cnt      <= 4'h0;
      tx_done_set <= 1'b0;
      sh_rx_take  <= 1'b0;
      fifo_pop    <= 1'b0;
      txd_out     <= 1'b1;
      rxd_out     <= 1'b1;
      rxd_oe_out  <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      sh_rx_take  <= 1'b0;
      fifo_pop    <= 1'b0;
      case (tx_st)
        IDLE: begin
          txd_out <= 1'b1;
          if (mode_shift & shift_lo & ~fifo_pop) begin
            if (fifo_valid) begin // RULE_11
              fifo_pop   <= 1'b1;
              tx_st      <= RUN;
              sh_dir     <= 1'b1;
              sh_cnt     <= 4'h0;
              sh_reg     <= fifo_data;
              rxd_out    <= fifo_data[0];
              rxd_oe_out <= 1'b1;
              txd_out    <= 1'b0;
            end else if (ctl[`FMSP_RX_EN] & ~ctl[`FMSP_RX_DONE]) begin // RULE_12
              tx_st      <= RUN;
              sh_dir     <= 1'b0;
              sh_cnt     <= 4'h0;
              rxd_oe_out <= 1'b0;
              txd_out    <= 1'b0;
            end
          end else if (~mode_shift & tx_bit & fifo_valid & ~fifo_pop) begin
            fifo_pop <= 1'b1; // RULE_19
            tx_st    <= RUN;
            tx_sh    <= {1'b1, (mode_nine ? ctl[`FMSP_TX9] : 1'b1),
                         fifo_data}; // RULE_07 RULE_14
            tx_cnt   <= mode_nine ? `FMSP_LEN_A9 : `FMSP_LEN_A8; // RULE_17
            txd_out  <= 1'b0; // RULE_13
          end
        end
        RUN: begin
          if (mode_shift) begin
            if (shift_hi) begin
              txd_out <= 1'b1;
              sh_reg  <= {rxd_in, sh_reg[7:1]};
              sh_cnt  <= sh_cnt + 4'h1;
              if (sh_cnt == `FMSP_SHIFT_BITS) begin
                tx_st      <= IDLE;
                rxd_oe_out <= 1'b0;
                rxd_out    <= 1'b1;
                tx_done_set <= sh_dir; // RULE_09
                sh_rx_take  <= ~sh_dir; // RULE_10
              end
            end else if (shift_lo) begin
              txd_out <= 1'b0;
              rxd_out <= sh_reg[0];
            end
          end else if (tx_bit) begin
            if (tx_cnt == 4'h1) begin
              tx_st <= IDLE;
            end else begin
              txd_out <= tx_sh[0];
              tx_sh   <= {1'b1, tx_sh[9:1]};
              tx_cnt  <= tx_cnt - 4'h1;
              if (tx_cnt == 4'h2) begin
                tx_done_set <= 1'b1; // RULE_09
              end
            end
          end
        end
        default: begin
          tx_st <= IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // async receive
  // ****************************************
  reg       rx_s1;
  reg       rx_s2;
  reg       rx_s3;
  reg       rx_st;
  reg [3:0] rx_ph;
  reg [3:0] rx_idx;
  reg [7:0] rx_sh;
  reg       rx_ninth;
  reg       a_take;
  reg       a_bit;
  reg [7:0] a_data;
  wire      rx_fall;
  wire      rx_mid;
  wire      rx_bit9;
  wire [3:0] rx_last;

  assign rx_fall = rx_s3 & ~rx_s2; // RULE_25
  assign rx_mid  = rx_os & (rx_ph == `FMSP_OVS_MID);
  assign rx_last = mode_nine ? `FMSP_RX_LAST_A9 : `FMSP_RX_LAST_A8;
  // ninth data bit in 9-bit modes, stop bit in 8-bit mode
  assign rx_bit9 = mode_nine ? rx_ninth : rx_s2; // RULE_08

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_s1    <= 1'b1;
      rx_s2    <= 1'b1;
      rx_s3    <= 1'b1;
      rx_st    <= IDLE;
      rx_ph    <= 4'h0;
      rx_idx   <= 4'h0;
      rx_sh    <= 8'h00;
      rx_ninth <= 1'b0;
      a_take   <= 1'b0;
      a_bit    <= 1'b0;
      a_data   <= 8'h00;
    end else begin
      rx_s1  <= rxd_in;
      rx_s2  <= rx_s1;
      rx_s3  <= rx_s2;
      a_take <= 1'b0;
      case (rx_st)
        IDLE: begin
          if (~mode_shift & ctl[`FMSP_RX_EN] & rx_fall) begin // RULE_06 RULE_15
            rx_st  <= RUN;
            rx_ph  <= 4'h0;
            rx_idx <= 4'h0;
          end
        end
        RUN: begin
          if (rx_os) begin
            rx_ph <= rx_ph + 4'h1;
          end
          if (rx_mid) begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == 4'h0) begin
              // glitch shorter than half a bit is not a start bit
              if (rx_s2) begin
                rx_st <= IDLE;
              end
            end else if (rx_idx <= `FMSP_RX_DATA_LAST) begin
              rx_sh <= {rx_s2, rx_sh[7:1]};
            end else if (rx_idx == rx_last) begin
              rx_st  <= IDLE;
              a_data <= rx_sh;
              a_bit  <= rx_bit9;
              // frame dropped if flag still set or filter fails
              a_take <= ~ctl[`FMSP_RX_DONE] &
                        (~ctl[`FMSP_MP_EN] | rx_bit9); // RULE_16 RULE_04 RULE_05
            end else if (rx_idx == `FMSP_RX_NINTH) begin
              rx_ninth <= rx_s2;
            end
          end
        end
        default: begin
          rx_st <= IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  wire ctl_wr;

  assign ctl_wr = sfr_wr_in & (sfr_addr_in == `FMSP_ADDR_CTL);

  always @(posedge core_clk_in) begin
    if (rst_in) begin
      ctl          <= `FMSP_CTL_RESET;
      rbuf         <= `FMSP_BUF_RESET;
      sfr_rdata_out <= 8'h00;
      tx_space_out <= 1'b0;
    end else begin
      tx_space_out <= fifo_in_ready;
      if (ctl_wr) begin
        ctl <= sfr_wdata_in;
      end
      // hardware set wins over a software clear in the same cycle
      if (tx_done_set) begin
        ctl[`FMSP_TX_DONE] <= 1'b1; // RULE_09
      end
      if (sh_rx_take) begin
        rbuf <= sh_reg;
        ctl[`FMSP_RX_DONE] <= 1'b1; // RULE_10
      end else if (a_take) begin
        rbuf <= a_data; // RULE_01
        ctl[`FMSP_RX9] <= a_bit; // RULE_08
        ctl[`FMSP_RX_DONE] <= 1'b1; // RULE_10
      end
      if (sfr_rd_in) begin
        case (sfr_addr_in)
          `FMSP_ADDR_CTL: sfr_rdata_out <= ctl;
          `FMSP_ADDR_BUF: sfr_rdata_out <= rbuf; // RULE_02
          default:        sfr_rdata_out <= 8'h00;
        endcase
      end
    end
  end
endmodule // fmsp_serial_port

/* File: design/fmsp_consts.vh */
`ifndef FMSP_CONSTS_VH
`define FMSP_CONSTS_VH

// ****************************************
// register addresses and reset values
// ****************************************
`define FMSP_ADDR_CTL      8'h98
`define FMSP_ADDR_BUF      8'h99
`define FMSP_CTL_RESET     8'h00
`define FMSP_BUF_RESET     8'h00

// ****************************************
// control field positions
// ****************************************
`define FMSP_MODE_HI       7
`define FMSP_MODE_LO       6
`define FMSP_MP_EN         5
`define FMSP_RX_EN         4
`define FMSP_TX9           3
`define FMSP_RX9           2
`define FMSP_TX_DONE       1
`define FMSP_RX_DONE       0

// ****************************************
// mode codes
// ****************************************
`define FMSP_MODE_SHIFT    2'b00
`define FMSP_MODE_A8_VAR   2'b01
`define FMSP_MODE_A9_FIX   2'b10
`define FMSP_MODE_A9_VAR   2'b11

// ****************************************
// timing counts
// ****************************************
`define FMSP_SHIFT_LAST    4'hb
`define FMSP_SHIFT_HALF    4'h6
`define FMSP_FIX_SLOW_LAST 2'h3
`define FMSP_FIX_FAST_LAST 2'h1
`define FMSP_OVS_LAST      4'hf
`define FMSP_OVS_MID       4'h7
`define FMSP_SHIFT_BITS    4'h7
`define FMSP_LEN_A8        4'ha
`define FMSP_LEN_A9        4'hb
`define FMSP_RX_LAST_A8    4'h9
`define FMSP_RX_LAST_A9    4'ha
`define FMSP_RX_NINTH      4'h9
`define FMSP_RX_DATA_LAST  4'h8

`endif

/* File: dv/fmsp_sp_props.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module fmsp_sp_props (
  // clock and reset
  input wire       core_clk_in,
  input wire       rst_in,
  // register port
  input wire [7:0] sfr_addr_in,
  input wire       sfr_wr_in,
  input wire       sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  input wire [7:0] sfr_rdata_out,
  // baud and pins
  input wire       baud_double_in,
  input wire       tx_clock_select_in,
  input wire       t1_ovf_tx_in,
  input wire       t2_ovf_tx_in,
  input wire       rxd_out,
  input wire       rxd_oe_out,
  input wire       txd_out
);
  reg  [1:0] mode;
  reg        rx_en;
  reg  [9:0] lo_run;
  reg  [7:0] ov_run;
  wire       ctl_wr = sfr_wr_in && sfr_addr_in == 8'h98;
  wire       tx_ov  = tx_clock_select_in ? t2_ovf_tx_in : t1_ovf_tx_in;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // mirror of written mode, hardware never alters it
  always @(posedge core_clk_in) begin
    if (rst_in) begin
      mode  <= 2'h0;
      rx_en <= 1'b0;
    end else if (ctl_wr) begin
      mode  <= sfr_wdata_in[7:6];
      rx_en <= sfr_wdata_in[4];
    end
  end
  // low-run length in cycles and in baud pulses
  always @(posedge core_clk_in) begin
    if (rst_in || txd_out) begin
      lo_run <= 10'h0;
      ov_run <= 8'h0;
    end else begin
      lo_run <= lo_run + 10'h1;
      ov_run <= ov_run + {7'h0, tx_ov};
    end
  end
  property p_reset_idle;
    $fell(rst_in) |-> txd_out && rxd_out && !rxd_oe_out
      && sfr_rdata_out == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("pins not idle after reset");
  property p_unmapped;
    sfr_rd_in && sfr_addr_in != 8'h98 && sfr_addr_in != 8'h99
      |=> sfr_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ctl_back;
    ctl_wr ##2 (sfr_rd_in && sfr_addr_in == 8'h98)
      |=> sfr_rdata_out[7:6] == mode && sfr_rdata_out[4] == rx_en;
  endproperty
  a_ctl_back: assert property (p_ctl_back)
    else $error("control readback differs");
  property p_oe_mode;
    rxd_oe_out |-> mode == 2'b00;
  endproperty
  a_oe_mode: assert property (p_oe_mode)
    else $error("data pin driven outside shift mode");
  property p_shift_low;
    mode == 2'b00 && $fell(txd_out) |-> (!txd_out)[*6] ##1 txd_out;
  endproperty
  a_shift_low: assert property (p_shift_low)
    else $error("shift clock low phase wrong");
  property p_fixed_bit;
    mode == 2'b10 && $rose(txd_out) |-> lo_run != 10'h0
      && lo_run % (baud_double_in ? 10'h20 : 10'h40) == 10'h0;
  endproperty
  a_fixed_bit: assert property (p_fixed_bit)
    else $error("fixed rate bit time wrong");
  property p_var_bit;
    mode[0] && $rose(txd_out) |-> ov_run != 8'h0 && ov_run[3:0] == 4'h0;
  endproperty
  a_var_bit: assert property (p_var_bit)
    else $error("variable bit not sixteen pulses");
  property p_rx_gate;
    mode == 2'b00 && !rx_en && $fell(txd_out) |-> ##[0:12] rxd_oe_out;
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("shift clock without enable");
endmodule // fmsp_sp_props

bind fmsp_serial_port fmsp_sp_props fmsp_sp_props_i (
  .core_clk_in, .rst_in, .sfr_addr_in, .sfr_wr_in, .sfr_rd_in,
  .sfr_wdata_in, .sfr_rdata_out, .baud_double_in, .tx_clock_select_in,
  .t1_ovf_tx_in, .t2_ovf_tx_in, .rxd_out, .rxd_oe_out, .txd_out
);

/* File: dv/fmsp_peer.sv */
`timescale 1ns/1ps
// ****
// remote serial peer
// ****
module fmsp_peer (
  // clock
  input  wire core_clk_in,
  // shift clock from the port
  input  wire txd_in,
  // line toward the receive pin
  output reg  line_out
);
  initial line_out = 1'b1;
  task wait_clk(input lvl);
    integer k;
    begin
      k = 0;
      while (txd_in !== lvl && k < 400) begin
        @(negedge core_clk_in);
        k = k + 1;
      end
    end
  endtask
  // start, data lsb first, stop; idle mark after
  task send(input [10:0] bits, input integer n, input integer per);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        line_out = bits[i];
        repeat (per) @(negedge core_clk_in);
      end
      line_out = 1'b1;
    end
  endtask
  // change data on the falling shift clock, away from sampling
  task shift_in(input [7:0] d);
    integer i;
    begin
      line_out = d[0];
      for (i = 0; i < 8; i = i + 1) begin
        wait_clk(1'b0);
        line_out = d[i];
        wait_clk(1'b1);
      end
      line_out = !d[7];
    end
  endtask
endmodule // fmsp_peer

/* File: dv/tb_fmsp_serial_port.sv */
`timescale 1ns/1ps
// ****
// serial port bench
// ****
module tb_fmsp_serial_port;
  reg         core_clk = 1'b0;
  reg         rst      = 1'b1;
  reg  [7:0]  addr     = 8'h00;
  reg         wr       = 1'b0;
  reg         rd       = 1'b0;
  reg  [7:0]  wdata    = 8'h00;
  reg         dbl      = 1'b0;
  reg         rsel     = 1'b0;
  reg         tsel     = 1'b0;
  reg  [3:0]  pcnt     = 4'h0;
  reg  [3:0]  qcnt     = 4'h0;
  reg         hold     = 1'b0;
  reg  [10:0] v;
  reg  [7:0]  r;
  wire [7:0]  rdata;
  wire        rxd_o;
  wire        rxd_oe;
  wire        txd;
  wire        tx_space;
  wire        peer_line;
  wire        t1       = pcnt == 4'h0;
  // hold stops the second timer so the buffer can fill without a pop
  wire        t2       = qcnt == 4'h0 && !hold;
  wire        rxd_pin  = rxd_oe ? rxd_o : peer_line;
  integer     errors   = 0;
  integer     compares = 0;
  integer     cyc      = 0;
  integer     i;
  integer     t0;
  always #10 core_clk = ~core_clk;
  // one-cycle overflow pulses, every 3 and every 5 clocks
  always @(negedge core_clk) begin
    pcnt <= (pcnt == 4'h2) ? 4'h0 : pcnt + 4'h1;
    qcnt <= (qcnt == 4'h4) ? 4'h0 : qcnt + 4'h1;
  end
  fmsp_serial_port fmsp_serial_port_i (
    .core_clk_in        (core_clk),
    .rst_in             (rst),
    .sfr_addr_in        (addr),
    .sfr_wr_in          (wr),
    .sfr_rd_in          (rd),
    .sfr_wdata_in       (wdata),
    .sfr_rdata_out      (rdata),
    .baud_double_in     (dbl),
    .rx_clock_select_in (rsel),
    .tx_clock_select_in (tsel),
    .t1_ovf_tx_in       (t1),
    .t2_ovf_tx_in       (t2),
    .t1_ovf_rx_in       (t1),
    .t2_ovf_rx_in       (t2),
    .rxd_in             (rxd_pin),
    .rxd_out            (rxd_o),
    .rxd_oe_out         (rxd_oe),
    .txd_out            (txd),
    .tx_space_out       (tx_space)
  );
  fmsp_peer fmsp_peer_i (
    .core_clk_in (core_clk),
    .txd_in      (txd),
    .line_out    (peer_line)
  );
  task tally_and_finish;
    begin
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  task chk(input [10:0] seen, input [10:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // idle cycle after each access keeps strobes single
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge core_clk);
      wr = 1'b0;
      @(negedge core_clk);
    end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    begin
      addr = a;
      rd = 1'b1;
      @(negedge core_clk);
      rd = 1'b0;
      @(negedge core_clk);
      d = rdata;
    end
  endtask
  task wait_txd(input lvl);
    integer k;
    begin
      k = 0;
      while (txd !== lvl && k < 2000) begin
        @(negedge core_clk);
        k = k + 1;
      end
      if (k == 2000) begin
        errors = errors + 1;
        $display("BAD %0t no edge on transmit pin", $time);
      end
    end
  endtask
  // sample each bit mid-way from the start edge
  task tx_case(input s, input b, input [7:0] c, input [7:0] d,
               input integer n, input integer per, input [10:0] e);
    begin
      tsel = s;
      dbl = b;
      wr_reg(8'h98, c);
      wr_reg(8'h99, d);
      wait_txd(1'b0);
      repeat (per / 2) @(negedge core_clk);
      v = 11'h7ff;
      for (i = 0; i < n; i = i + 1) begin
        v[i] = txd;
        repeat (per) @(negedge core_clk);
      end
      chk(v, e);
      rd_reg(8'h98, r);
      chk(r, c | 8'h02);
    end
  endtask
  task rx_case(input s, input [7:0] c, input [10:0] f, input integer n,
               input integer per, input [7:0] ec, input [7:0] eb);
    begin
      rsel = s;
      wr_reg(8'h98, c);
      fmsp_peer_i.send(f, n, per);
      repeat (per) @(negedge core_clk);
      rd_reg(8'h98, r);
      chk(r, ec);
      rd_reg(8'h99, r);
      chk(r, eb);
    end
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk({txd, rxd_o, rxd_oe}, 3'b110);
    rd_reg(8'h98, r);
    chk(r, 8'h00);
    wr_reg(8'h98, 8'he8);
    rd_reg(8'h98, r);
    chk(r, 8'he8);
    rd_reg(8'h9a, r);
    chk(r, 8'h00);
    tx_case(0, 1, 8'h88, 8'ha5, 11, 32, {2'b11, 8'ha5, 1'b0});
    tx_case(0, 0, 8'h80, 8'h5a, 11, 64, {2'b10, 8'h5a, 1'b0});
    tx_case(1, 0, 8'h40, 8'hc3, 10, 80, {2'b11, 8'hc3, 1'b0});
    tx_case(0, 1, 8'hc0, 8'h3e, 11, 48, {2'b10, 8'h3e, 1'b0});
    rx_case(0, 8'h50, {2'b11, 8'h3c, 1'b0}, 10, 48, 8'h55, 8'h3c);
    rx_case(0, 8'h55, {2'b11, 8'h77, 1'b0}, 10, 48, 8'h55, 8'h3c);
    rx_case(0, 8'h70, {2'b10, 8'h77, 1'b0}, 10, 48, 8'h70, 8'h3c);
    rx_case(1, 8'hf0, {2'b10, 8'h41, 1'b0}, 11, 80, 8'hf0, 8'h3c);
    rx_case(1, 8'hf0, {2'b11, 8'h96, 1'b0}, 11, 80, 8'hf5, 8'h96);
    rx_case(0, 8'h90, {2'b11, 8'h5e, 1'b0}, 11, 32, 8'h95, 8'h5e);
    rx_case(0, 8'h40, {2'b11, 8'h11, 1'b0}, 10, 48, 8'h40, 8'h5e);
    // fill past depth with the bit clock held, then drain all frames
    tsel = 1'b1;
    hold = 1'b1;
    wr_reg(8'h98, 8'h40);
    for (i = 0; i < 17; i = i + 1)
      wr_reg(8'h99, i[7:0]);
    chk(tx_space, 1'b0);
    hold = 1'b0;
    // mode change mid-frame is unsupported: wait out all sixteen frames
    repeat (14300) @(negedge core_clk);
    chk(tx_space, 1'b1);
    wr_reg(8'h98, 8'h00);
    wr_reg(8'h99, 8'h6b);
    // data stands through the low phase; released at the last rise
    for (t0 = 0; t0 < 8; t0 = t0 + 1) begin
      wait_txd(1'b0);
      r[t0] = rxd_o;
      chk(rxd_oe, 1'b1);
      wait_txd(1'b1);
      if (t0 == 0)
        i = cyc;
      if (t0 == 1)
        chk(cyc - i, 11'h00c);
    end
    chk(r, 8'h6b);
    repeat (12) @(negedge core_clk);
    rd_reg(8'h98, r);
    chk(r, 8'h02);
    fork
      fmsp_peer_i.shift_in(8'hd2);
      wr_reg(8'h98, 8'h10);
    join
    // done flag lands one cycle after the last shift
    repeat (2) @(negedge core_clk);
    rd_reg(8'h98, r);
    chk(r, 8'h11);
    rd_reg(8'h99, r);
    chk(r, 8'hd2);
    tally_and_finish;
  end
endmodule // tb_fmsp_serial_port
